// [inc/rsf_params.svh]
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH

// register page and addresses
`define RSF_PAGE_MAIN      8'h00
`define RSF_ADDR_CAUSE     8'hEF
`define RSF_ADDR_IRQ_STAT  8'hE0
`define RSF_ADDR_IRQ_MASK  8'hE1
`define RSF_ADDR_WDT_CTL   8'hE2

// cause register field positions
`define RSF_BIT_PIN        0
`define RSF_BIT_POR        1
`define RSF_BIT_MCD        2
`define RSF_BIT_WDT        3
`define RSF_BIT_SOFT       4
`define RSF_BIT_CMP        5
`define RSF_BIT_FERR       6
`define RSF_BIT_UNUSED     7

// watchdog control field positions
`define RSF_WDT_BIT_EN     0
`define RSF_WDT_BIT_KICK   1

// reset values
`define RSF_MASK_RST       7'h00
`define RSF_VDD_EN_RST     1'b1

// timing
`define RSF_CLK_NS         100
`define RSF_HOLD_NS        1000
`define RSF_HOLD_CYC       ((`RSF_HOLD_NS + `RSF_CLK_NS - 1) / `RSF_CLK_NS)
`define RSF_WDT_DIV        12
`define RSF_WDT_TICKS      256

`endif

// [inc/rsf_pkg.sv]
package rsf_pkg;

  typedef enum logic [0:0] {
    RSF_RUN  = 1'b0,
    RSF_HOLD = 1'b1
  } rsf_state_t;

  typedef logic [6:0] rsf_cause_t;

endpackage : rsf_pkg

// [core/rsf_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module rsf_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      stage1 <= INIT[WIDTH-1:0];
      sync_o <= INIT[WIDTH-1:0];
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : rsf_sync

`default_nettype wire

// [core/rsf_wdt.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rsf_params.svh"

module rsf_wdt #(
  parameter logic [15:0] TICKS = 16'(`RSF_WDT_TICKS)
) (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic sys_rst_i,
  input  wire logic ctl_wr_i,
  input  wire logic en_i,
  input  wire logic kick_i,
  output var  logic en_o,
  output var  logic ovf_o
);

  localparam logic [3:0] DIV_LAST = 4'(`RSF_WDT_DIV - 1);

  logic [3:0]  prescale;
  logic [15:0] count;
  wire         tick     = (prescale == DIV_LAST);
  wire         at_limit = (count == TICKS - 16'h0001);

  // enabled and running from sysclk/12 after any reset
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || sys_rst_i) begin
      prescale <= 4'h0;
      count    <= 16'h0000;
      en_o     <= 1'b1;
      ovf_o    <= 1'b0;
    end else begin
      prescale <= tick ? 4'h0 : prescale + 4'h1;
      ovf_o    <= 1'b0;
      if (ctl_wr_i) begin
        en_o <= en_i;
      end
      if (kick_i || !en_o) begin
        count <= 16'h0000;
      end else if (tick) begin
        count <= at_limit ? 16'h0000 : count + 16'h0001;
        ovf_o <= at_limit;
      end
    end
  end

endmodule : rsf_wdt

`default_nettype wire

// [core/rsf_reset_source.sv]
// Notes on behaviour
// - flash access fault sets bit 6 as cause of last reset
// - bit 5 write enables comparator reset; read shows comparator caused reset
// - writing one to bit 4 forces reset; bit 4 then reads one
// - watchdog overflow reset sets bit 3
// - bit 2 write enables clock loss detector; reads one after its reset
// - bit 1 write enables supply monitor as reset source
// - bit 1 reads one after power-on or supply monitor reset
// - while power-on flag is set other cause flags are undefined
// - external reset pin low sets bit 0
// - cause register sits at address EF on page 00
// - writing zero to bit 2 disables clock loss detector
// - enabled comparator holds reset while its output is low
// - after any reset watchdog runs enabled from clock divided by twelve
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_params.svh"

module rsf_reset_source #(
  parameter logic [15:0] WDT_TICKS = 16'(`RSF_WDT_TICKS)
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rstn_i,
  input  wire logic [7:0]         page_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output var  logic [7:0]         rdata_o,
  input  wire logic               pin_rst_n_i,
  input  wire logic               vdd_ok_i,
  input  wire logic               cmp_out_i,
  input  wire logic               clk_missing_i,
  input  wire logic               flash_fault_i,
  output var  logic               sys_reset_o,
  output var  logic               wdt_en_o,
  output var  rsf_pkg::rsf_cause_t last_cause_o,
  output var  logic               irq_o
);

  import rsf_pkg::*;

  localparam logic [3:0] HOLD_CYC = 4'(`RSF_HOLD_CYC);

  rsf_state_t state;
  logic [3:0] hold_cnt;
  rsf_cause_t pend;
  rsf_cause_t flags;
  rsf_cause_t irq_stat;
  rsf_cause_t irq_mask;
  logic       cmp_en;
  logic       mcd_en;
  logic       vdd_en;
  logic       pin_n_s;
  logic       vdd_ok_s;
  logic       cmp_s;
  logic       miss_s;
  logic       wdt_ovf;

  rsf_sync #(
    .WIDTH (4),
    .INIT  (32'h0000_000F)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({pin_rst_n_i, vdd_ok_i, cmp_out_i, clk_missing_i}),
    .sync_o    ({pin_n_s, vdd_ok_s, cmp_s, miss_s})
  );

  // register decode
  wire page_ok  = (page_i == `RSF_PAGE_MAIN);
  wire sel_cause = page_ok && (addr_i == `RSF_ADDR_CAUSE);
  wire sel_stat  = page_ok && (addr_i == `RSF_ADDR_IRQ_STAT);
  wire sel_mask  = page_ok && (addr_i == `RSF_ADDR_IRQ_MASK);
  wire sel_wdt   = page_ok && (addr_i == `RSF_ADDR_WDT_CTL);
  wire wr_cause  = wr_i && sel_cause;
  wire wr_wdt    = wr_i && sel_wdt;
  wire running   = (state == RSF_RUN);

  rsf_wdt #(
    .TICKS (WDT_TICKS)
  ) u_wdt (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .sys_rst_i (sys_reset_o),
    .ctl_wr_i  (wr_wdt),
    .en_i      (wdata_i[`RSF_WDT_BIT_EN]),
    .kick_i    (wr_wdt && wdata_i[`RSF_WDT_BIT_KICK]),
    .en_o      (wdt_en_o),
    .ovf_o     (wdt_ovf)
  );

  // reset causes seen this cycle
  wire pin_req  = !pin_n_s;
  wire vdd_req  = vdd_en && !vdd_ok_s;
  wire cmp_req  = cmp_en && !cmp_s;
  wire mcd_req  = mcd_en && miss_s;
  wire soft_req = wr_cause && running && wdata_i[`RSF_BIT_SOFT];
  wire ferr_req = flash_fault_i && running;
  wire wdt_req  = wdt_ovf && running;

  rsf_cause_t cause_now;
  assign cause_now[`RSF_BIT_PIN]  = pin_req;
  assign cause_now[`RSF_BIT_POR]  = vdd_req;
  assign cause_now[`RSF_BIT_MCD]  = mcd_req;
  assign cause_now[`RSF_BIT_WDT]  = wdt_req;
  assign cause_now[`RSF_BIT_SOFT] = soft_req;
  assign cause_now[`RSF_BIT_CMP]  = cmp_req;
  assign cause_now[`RSF_BIT_FERR] = ferr_req;

  // level sources keep the system in reset
  wire level_hold = pin_req || vdd_req || cmp_req;
  wire release_now = !running && (hold_cnt == 4'h0) && !level_hold;

  // power-on clears the others, they are undefined to software
  wire        por_exit = pend[`RSF_BIT_POR];
  rsf_cause_t next_flags;
  assign next_flags = por_exit ? 7'(1 << `RSF_BIT_POR) : pend;

  wire        stat_clr_wr = wr_i && sel_stat;
  rsf_cause_t stat_set;
  assign stat_set = release_now ? next_flags : 7'h00;

  // read mux; bit 7 always reads zero
  logic [7:0] next_rdata;
  assign next_rdata = sel_cause ? {1'b0, flags} :
                      sel_stat  ? {1'b0, irq_stat} :
                      sel_mask  ? {1'b0, irq_mask} :
                      sel_wdt   ? {7'h00, wdt_en_o} : 8'h00;

  assign sys_reset_o  = !running;
  assign last_cause_o = flags;
  assign irq_o        = |(irq_stat & irq_mask);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state    <= RSF_HOLD;
      hold_cnt <= HOLD_CYC;
      pend     <= 7'(1 << `RSF_BIT_POR);
      flags    <= 7'h00;
    end else if (running) begin
      if (|cause_now) begin
        state    <= RSF_HOLD;
        hold_cnt <= HOLD_CYC;
        pend     <= cause_now;
      end
    end else begin
      pend     <= pend | cause_now;
      hold_cnt <= (hold_cnt == 4'h0) ? 4'h0 : hold_cnt - 4'h1;
      if (release_now) begin
        state <= RSF_RUN;
        flags <= next_flags;
      end
    end
  end

  // enables; writes to read-only flags and bit 7 have no effect
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cmp_en <= 1'b0;
      mcd_en <= 1'b0;
      vdd_en <= `RSF_VDD_EN_RST;
    end else if (release_now) begin
      cmp_en <= 1'b0;
      mcd_en <= 1'b0;
    end else if (wr_cause && running) begin
      cmp_en <= wdata_i[`RSF_BIT_CMP];
      mcd_en <= wdata_i[`RSF_BIT_MCD];
      vdd_en <= wdata_i[`RSF_BIT_POR];
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      irq_stat <= 7'h00;
      irq_mask <= `RSF_MASK_RST;
      rdata_o  <= 8'h00;
    end else begin
      irq_stat <= (irq_stat & ~(stat_clr_wr ? wdata_i[6:0] : 7'h00)) | stat_set;
      if (wr_i && sel_mask) begin
        irq_mask <= wdata_i[6:0];
      end
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  a_soft_force: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wr_cause && wdata_i[`RSF_BIT_SOFT] |=> sys_reset_o [*8] ##[1:20]
    (!sys_reset_o && (flags[`RSF_BIT_SOFT] || flags[`RSF_BIT_POR])))
    else $error("soft force did not reset or flag");

  a_ferr_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && flash_fault_i && !por_exit |=> ##[1:20]
    (!sys_reset_o && flags[`RSF_BIT_FERR]))
    else $error("flash fault not recorded");

  a_wdt_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wdt_ovf |=> sys_reset_o)
    else $error("watchdog overflow did not reset");

  a_cmp_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sys_reset_o && cmp_en && !cmp_s |=> sys_reset_o)
    else $error("comparator low released reset");

  a_mcd_disable: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wr_cause && !wdata_i[`RSF_BIT_MCD] && !mcd_req |=> !mcd_en)
    else $error("clock loss detector not disabled");

  a_por_only: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    release_now && pend[`RSF_BIT_POR] |=> flags == 7'(1 << `RSF_BIT_POR))
    else $error("power-on flag pattern wrong");

  a_pin_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    release_now && pend[`RSF_BIT_PIN] && !pend[`RSF_BIT_POR] |=> flags[`RSF_BIT_PIN])
    else $error("pin reset not recorded");

  a_bit7_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && sel_cause |=> rdata_o == {1'b0, $past(flags)})
    else $error("cause readback wrong");

  a_wdt_on_exit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(sys_reset_o) |-> wdt_en_o)
    else $error("watchdog not enabled after reset");

  a_pin_enter: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && pin_req |=> sys_reset_o)
    else $error("pin low did not reset");

  a_cmp_enter: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && cmp_req |=> sys_reset_o)
    else $error("comparator low did not reset");

  a_mcd_enter: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && mcd_req |=> sys_reset_o)
    else $error("missing clock did not reset");

  a_vdd_enter: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && vdd_req |=> sys_reset_o)
    else $error("supply drop did not reset");

  a_hold_min: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && (|cause_now) |=> sys_reset_o [*8] ##1 sys_reset_o ##1 sys_reset_o)
    else $error("system reset shorter than hold time");

  a_ro_ignore: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wr_cause |=> flags == $past(flags))
    else $error("cause write changed the flags");

  a_cmp_en_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wr_cause |=> cmp_en == $past(wdata_i[`RSF_BIT_CMP]))
    else $error("comparator enable not written");

  a_vdd_en_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wr_cause |=> vdd_en == $past(wdata_i[`RSF_BIT_POR]))
    else $error("supply monitor enable not written");

  a_mcd_enable: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && wr_cause && wdata_i[`RSF_BIT_MCD] |=> mcd_en)
    else $error("clock loss detector not enabled");

  a_wdt_en_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sys_reset_o |=> wdt_en_o)
    else $error("watchdog not forced on in reset");

  a_page_decode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && !page_ok |=> rdata_o == 8'h00)
    else $error("other page read returned data");

  a_mcd_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    release_now && pend[`RSF_BIT_MCD] && !pend[`RSF_BIT_POR] |=> flags[`RSF_BIT_MCD])
    else $error("clock loss reset not recorded");

  a_cmp_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    release_now && pend[`RSF_BIT_CMP] && !pend[`RSF_BIT_POR] |=> flags[`RSF_BIT_CMP])
    else $error("comparator reset not recorded");

  a_wdt_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    release_now && pend[`RSF_BIT_WDT] && !pend[`RSF_BIT_POR] |=> flags[`RSF_BIT_WDT])
    else $error("watchdog reset not recorded");

  a_soft_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    release_now && pend[`RSF_BIT_SOFT] && !pend[`RSF_BIT_POR] |=> flags[`RSF_BIT_SOFT])
    else $error("soft reset not recorded");

endmodule : rsf_reset_source

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rsf_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
  import rsf_pkg::*;
  logic             clk = 1'b0;
  logic             rstn, wr, rd, pin_n, vdd, cmp, cmiss, ffault;
  logic [7:0]       page, addr, wdata, rdata, d;
  logic             sys_rst, wdt_en, irq;
  rsf_cause_t       cause;
  int               fail_count, compares, cnt, hold_len;
  logic [7:0]       q [$];

  rsf_reset_source #(.WDT_TICKS(16'h0004)) u_rsf_reset_source (
    .sys_clk_i(clk), .rstn_i(rstn), .page_i(page), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_rst_n_i(pin_n), .vdd_ok_i(vdd),
    .cmp_out_i(cmp), .clk_missing_i(cmiss), .flash_fault_i(ffault),
    .sys_reset_o(sys_rst), .wdt_en_o(wdt_en), .last_cause_o(cause), .irq_o(irq)
  );

  always #50 clk = ~clk;

  // cycles spent in system reset, sampled away from the launching edge
  always @(negedge clk) hold_len <= (sys_rst === 1'b1) ? hold_len + 1 : 0;

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic wait_rise;
    cnt = 0;
    while (sys_rst !== 1'b1 && cnt < 200) begin
      @(posedge clk);
      #1 cnt++;
    end
    `CHK(sys_rst, 1'b1)
  endtask : wait_rise

  // keep_wdt leaves the watchdog running so it can time out next
  task automatic wait_fall(input bit keep_wdt);
    logic [7:0] exp;
    cnt = 0;
    while (sys_rst !== 1'b0 && cnt < 300) begin
      @(posedge clk);
      #1 cnt++;
    end
    `CHK(hold_len >= `RSF_HOLD_CYC, 1'b1)
    `CHK(wdt_en, 1'b1)
    exp = q.pop_front();
    rd_reg(8'hEF, d);
    if (exp[1]) begin
      // power-on leaves the other flags unknown
      `CHK(cause[1], 1'b1)
      `CHK({d[7], d[1]}, 2'b01)
    end else begin
      `CHK(cause, exp[6:0])
      `CHK(d, exp)
    end
    if (!keep_wdt) begin
      wr_reg(`RSF_ADDR_WDT_CTL, 8'h00);
    end
  endtask : wait_fall

  initial begin
    #(5000 * 100);
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h9C1E));
    {rstn, wr, rd, cmp, cmiss, ffault} = '0;
    {pin_n, vdd} = 2'b11;
    {page, addr, wdata} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    q.push_back(8'h02);
    wait_fall(1'b0);
    $display("power-on test done");
    rd_reg(`RSF_ADDR_IRQ_STAT, d);
    `CHK(d[1], 1'b1)
    wr_reg(`RSF_ADDR_IRQ_MASK, 8'h7D);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    wr_reg(`RSF_ADDR_IRQ_MASK, 8'h7F);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    wr_reg(`RSF_ADDR_IRQ_STAT, 8'h7F);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    $display("interrupt test done");
    rd_reg(8'hEE, d);
    `CHK(d, 8'h00)
    wr_reg(8'hEE, 8'($urandom));
    page <= 8'($urandom_range(255, 1));
    rd_reg(8'hEF, d);
    `CHK(d, 8'h00)
    page <= 8'h00;
    // disabled comparator and detector must not reset
    {cmp, cmiss} <= 2'($urandom);
    wr_reg(8'hEF, 8'hC9);
    rd_reg(8'hEF, d);
    `CHK({d[7], d[1]}, 2'b01)
    `CHK(sys_rst, 1'b0)
    wr_reg(8'hEF, 8'h02);
    {cmp, cmiss} <= 2'b00;
    $display("access test done");
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: begin
          q.push_back(8'h10);
          wr_reg(8'hEF, 8'h10);
        end
        1: begin
          q.push_back(8'h01);
          pin_n <= 1'b0;
          repeat (3 + $urandom % 6) @(posedge clk);
          pin_n <= 1'b1;
        end
        2: begin
          q.push_back(8'h40);
          @(posedge clk);
          ffault <= 1'b1;
          @(posedge clk);
          ffault <= 1'b0;
        end
        3: begin
          q.push_back(8'h04);
          wr_reg(8'hEF, 8'h04);
          cmiss <= 1'b1;
          repeat (3 + $urandom % 4) @(posedge clk);
          cmiss <= 1'b0;
        end
        default: q.push_back(8'h08);
      endcase
      wait_rise();
      wait_fall(k == 3);
      $display("source test %0d done", k);
    end
    wr_reg(8'hEF, 8'h20);
    cmp <= 1'b0;
    wait_rise();
    // flash faults during system reset are refused
    ffault <= 1'($urandom);
    repeat (20) @(posedge clk);
    #1 `CHK(sys_rst, 1'b1)
    cmp <= 1'b1;
    ffault <= 1'b0;
    q.push_back(8'h20);
    wait_fall(1'b0);
    $display("comparator test done");
    wr_reg(8'hEF, 8'h04);
    wr_reg(8'hEF, 8'h00);
    cmiss <= 1'b1;
    repeat (20) @(posedge clk);
    #1 `CHK(sys_rst, 1'b0)
    cmiss <= 1'b0;
    $display("detector disable test done");
    wr_reg(8'hEF, 8'h02);
    vdd <= 1'b0;
    wait_rise();
    repeat (4) @(posedge clk);
    vdd <= 1'b1;
    q.push_back(8'h02);
    wait_fall(1'b0);
    $display("supply test done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
